/* File: logic/ebm_core.sv */
// block memory core: user write and read ports plus apb control
//
// Functional notes
// (R1) 256 words of 16 bits, split paths
// (R2) addresses and write data registered first
// (R3) mask bit 0 writes, 1 keeps
// (R4) 8-bit write address picks location
// (R5) independent 8-bit read address picks location
// (R6) write edge rising, falling optional
// (R7) read edge rising, falling optional, independent
// (R8) write enable and write clock gate
// (R9) read enable and read clock gate
// (R10) optional preload during configuration
// (R11) rom use: preload, write controls off
// (R12) location zero cannot be preloaded
// (R13) write only with both enables set
// (R14) read data updates only when enabled
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module ebm_core #(
  parameter int ADDR_W = ebm_pkg::ADDR_W,
  parameter int DATA_W = ebm_pkg::DATA_W,
  parameter int DEPTH = ebm_pkg::DEPTH
) (
  input wire logic pclk,                                  // system clock
  input wire logic presetn,                               // async reset, active low
  input wire logic [ebm_pkg::APB_ADDR_W-1:0] paddr,       // apb address
  input wire logic psel,                                  // apb select
  input wire logic penable,                               // apb enable
  input wire logic pwrite,                                // apb direction
  input wire logic [ebm_pkg::APB_DATA_W-1:0] pwdata,      // apb write data
  output logic pready,                                    // apb ready
  output logic [ebm_pkg::APB_DATA_W-1:0] prdata,          // apb read data
  output logic pslverr,                                   // apb error
  input wire logic wr_clk,                                // write port clock level
  input wire logic wr_clock_gate,                         // write clock enable
  input wire logic wr_enable,                             // write enable
  input wire logic [ADDR_W-1:0] wr_location,              // write address
  input wire logic [DATA_W-1:0] wr_data,                  // write data
  input wire logic [DATA_W-1:0] wr_mask,                  // per-bit keep mask
  input wire logic rd_clk,                                // read port clock level
  input wire logic rd_clock_gate,                         // read clock enable
  input wire logic fetch_strobe,                          // read enable
  input wire logic [ADDR_W-1:0] rd_location,              // read address
  output logic [DATA_W-1:0] rd_data                       // read data
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    ebm_pkg::ebm_bus_state_type bus;
    logic [ebm_pkg::CTRL_W-1:0] ctrl;
    logic [ADDR_W-1:0] pre_addr;
    logic [DATA_W-1:0] pre_data;
    logic reject;
    logic [ebm_pkg::APB_DATA_W-1:0] prdata;
    logic pslverr;
    logic w_pend;
    logic [ADDR_W-1:0] w_addr;
    logic [DATA_W-1:0] w_data;
    logic [DATA_W-1:0] w_mask;
    logic p_pend;
    logic [ADDR_W-1:0] p_addr;
    logic [DATA_W-1:0] p_data;
    logic r_pend;
    logic [ADDR_W-1:0] r_addr;
    logic [DATA_W-1:0] rd_data;
    logic [DATA_W-1:0] wcount;
  } ebm_core_state_type;

  ebm_core_state_type s_q;
  ebm_core_state_type s_d;

  logic wr_edge;
  logic rd_edge;
  logic [DATA_W-1:0] rd_word;
  logic store_go;
  logic [ADDR_W-1:0] store_addr;
  logic [DATA_W-1:0] store_data;
  logic [DATA_W-1:0] store_keep;
  logic hit_ctrl;
  logic hit_pre_addr;
  logic hit_pre_data;
  logic hit_status;
  logic hit_wcount;
  logic mapped;
  logic [ebm_pkg::APB_DATA_W-1:0] read_mux;
  logic [ebm_pkg::APB_DATA_W-1:0] status_word;
  logic user_wr_ok;
  logic preload_ok;

  function automatic logic is_reg(input logic [ebm_pkg::APB_ADDR_W-1:0] a,
                                  input logic [ebm_pkg::APB_ADDR_W-1:0] ofs);
    is_reg = (a == ofs);
  endfunction

  function automatic logic [ebm_pkg::APB_DATA_W-1:0] widen(input logic [DATA_W-1:0] v);
    widen = '0;
    widen[DATA_W-1:0] = v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // port clock edges

  ebm_edge_pick u_wr_edge (
    .pclk(pclk),
    .presetn(presetn),
    .level_in(wr_clk),
    .fall_sel(s_q.ctrl[ebm_pkg::CTRL_WR_FALL]), // see (R6)
    .edge_pulse(wr_edge)
  );

  ebm_edge_pick u_rd_edge (
    .pclk(pclk),
    .presetn(presetn),
    .level_in(rd_clk),
    .fall_sel(s_q.ctrl[ebm_pkg::CTRL_RD_FALL]), // see (R7)
    .edge_pulse(rd_edge)
  );

  ////////////////////////////////////////////////////////////////////////////
  // storage

  // user write first; preload waits a cycle if both pend
  assign store_go = s_q.w_pend | s_q.p_pend;
  assign store_addr = s_q.w_pend ? s_q.w_addr : s_q.p_addr;
  assign store_data = s_q.w_pend ? s_q.w_data : s_q.p_data;
  assign store_keep = s_q.w_pend ? s_q.w_mask : '0;

  ebm_store #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W),
    .DEPTH(DEPTH)
  ) u_store (
    .pclk(pclk),
    .wr_go(store_go),
    .wr_addr(store_addr),
    .wr_data(store_data),
    .wr_keep(store_keep),
    .rd_addr(s_q.r_addr),
    .rd_word(rd_word)
  ); // see (R1)

  ////////////////////////////////////////////////////////////////////////////
  // register decode

  assign hit_ctrl = is_reg(paddr, ebm_pkg::CTRL_OFS);
  assign hit_pre_addr = is_reg(paddr, ebm_pkg::PRE_ADDR_OFS);
  assign hit_pre_data = is_reg(paddr, ebm_pkg::PRE_DATA_OFS);
  assign hit_status = is_reg(paddr, ebm_pkg::STATUS_OFS);
  assign hit_wcount = is_reg(paddr, ebm_pkg::WCOUNT_OFS);
  assign mapped = hit_ctrl | hit_pre_addr | hit_pre_data | hit_status | hit_wcount;

  always_comb begin
    status_word = '0;
    status_word[ebm_pkg::STAT_CFG] = s_q.ctrl[ebm_pkg::CTRL_CFG];
    status_word[ebm_pkg::STAT_REJECT] = s_q.reject;
    status_word[ebm_pkg::STAT_ROM] = s_q.ctrl[ebm_pkg::CTRL_ROM];
    status_word[ebm_pkg::STAT_RDATA_LSB +: DATA_W] = s_q.rd_data;
  end

  always_comb begin
    read_mux = '0;
    if (hit_ctrl) begin
      read_mux[ebm_pkg::CTRL_W-1:0] = s_q.ctrl;
    end else if (hit_pre_addr) begin
      read_mux[ADDR_W-1:0] = s_q.pre_addr;
    end else if (hit_pre_data) begin
      read_mux = widen(s_q.pre_data);
    end else if (hit_status) begin
      read_mux = status_word;
    end else if (hit_wcount) begin
      read_mux = widen(s_q.wcount);
    end
  end

  // user writes locked out while loading or in rom use
  assign user_wr_ok = wr_edge & wr_enable & wr_clock_gate // see (R8) (R13)
                      & ~s_q.ctrl[ebm_pkg::CTRL_CFG] & ~s_q.ctrl[ebm_pkg::CTRL_ROM]; // see (R11)
  assign preload_ok = s_q.ctrl[ebm_pkg::CTRL_CFG] & (s_q.pre_addr != ebm_pkg::NO_INIT_LOC); // see (R12)

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_d = s_q;
    s_d.w_pend = 1'h0;
    s_d.r_pend = 1'h0;
    if (s_q.p_pend && !s_q.w_pend) begin
      s_d.p_pend = 1'h0;
    end

    // write port input registers
    if (user_wr_ok) begin
      s_d.w_pend = 1'h1;
      s_d.w_addr = wr_location; // see (R2) (R4)
      s_d.w_data = wr_data; // see (R2)
      s_d.w_mask = wr_mask; // see (R3)
    end

    // read port input register
    if (rd_edge && fetch_strobe && rd_clock_gate) begin
      s_d.r_pend = 1'h1; // see (R9) (R14)
      s_d.r_addr = rd_location; // see (R2) (R5)
    end
    if (s_q.r_pend) begin
      s_d.rd_data = rd_word; // see (R14)
    end

    // apb: one wait state, write lands at the completing edge
    case (s_q.bus)
      ebm_pkg::EBM_BUS_IDLE: begin
        if (psel && penable) begin
          s_d.bus = ebm_pkg::EBM_BUS_ACK;
          s_d.prdata = pwrite ? '0 : read_mux;
          s_d.pslverr = ~mapped;
        end
      end
      ebm_pkg::EBM_BUS_ACK: begin
        s_d.bus = ebm_pkg::EBM_BUS_IDLE;
        if (pwrite && mapped) begin
          if (hit_ctrl) begin
            s_d.ctrl = pwdata[ebm_pkg::CTRL_W-1:0];
          end else if (hit_pre_addr) begin
            s_d.pre_addr = pwdata[ADDR_W-1:0];
          end else if (hit_pre_data) begin
            s_d.pre_data = pwdata[DATA_W-1:0];
            s_d.reject = ~preload_ok;
            if (preload_ok) begin
              s_d.p_pend = 1'h1; // see (R10)
              s_d.p_addr = s_q.pre_addr;
              s_d.p_data = pwdata[DATA_W-1:0];
            end
          end else if (hit_wcount) begin
            s_d.wcount = '0;
          end
        end
      end
      default: begin
        s_d.bus = ebm_pkg::EBM_BUS_IDLE;
      end
    endcase

    // count committed user writes; a commit beats a clear
    s_d.wcount = s_d.wcount + DATA_W'(s_q.w_pend);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.bus <= ebm_pkg::EBM_BUS_IDLE;
      s_q.ctrl <= ebm_pkg::CTRL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign pready = (s_q.bus == ebm_pkg::EBM_BUS_ACK);
  assign prdata = s_q.prdata;
  assign pslverr = s_q.pslverr & pready;
  assign rd_data = s_q.rd_data;

endmodule
`default_nettype wire

/* File: logic/ebm_pkg.sv */
// shared constants and types for the embedded block memory
package ebm_pkg;

  // array geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int DEPTH = 256;

  // apb side
  localparam int APB_ADDR_W = 8;
  localparam int APB_DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] PRE_ADDR_OFS = 8'h04;
  localparam logic [7:0] PRE_DATA_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;
  localparam logic [7:0] WCOUNT_OFS = 8'h10;

  // control register fields
  localparam int CTRL_W = 4;
  localparam int CTRL_WR_FALL = 0;
  localparam int CTRL_RD_FALL = 1;
  localparam int CTRL_CFG = 2;
  localparam int CTRL_ROM = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // status register fields
  localparam int STAT_CFG = 0;
  localparam int STAT_REJECT = 1;
  localparam int STAT_ROM = 2;
  localparam int STAT_RDATA_LSB = 16;

  // location that preloading can never reach
  localparam logic [7:0] NO_INIT_LOC = 8'h00;

  // apb answer sequencing
  typedef enum {EBM_BUS_IDLE, EBM_BUS_ACK} ebm_bus_state_type;

endpackage

/* File: logic/ebm_edge_pick.sv */
// picks the active edge of a sampled port clock
`timescale 1ns/100ps
`default_nettype none
module ebm_edge_pick (
  input wire logic pclk,        // system clock
  input wire logic presetn,     // async reset, active low
  input wire logic level_in,    // sampled port clock level
  input wire logic fall_sel,    // 1 selects the falling edge
  output logic edge_pulse       // one cycle on the active edge
);

  typedef struct packed {
    logic prev;
  } ebm_edge_state_type;

  ebm_edge_state_type s_q;
  ebm_edge_state_type s_d;

  always_comb begin
    s_d = s_q;
    s_d.prev = level_in;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign edge_pulse = fall_sel ? (s_q.prev & ~level_in) : (~s_q.prev & level_in);

endmodule
`default_nettype wire

/* File: logic/ebm_store.sv */
// storage array with bit-masked write and direct read
`timescale 1ns/100ps
`default_nettype none
module ebm_store #(
  parameter int ADDR_W = ebm_pkg::ADDR_W,
  parameter int DATA_W = ebm_pkg::DATA_W,
  parameter int DEPTH = ebm_pkg::DEPTH
) (
  input wire logic pclk,                  // system clock
  input wire logic wr_go,                 // commit a write this edge
  input wire logic [ADDR_W-1:0] wr_addr,  // write location
  input wire logic [DATA_W-1:0] wr_data,  // write data
  input wire logic [DATA_W-1:0] wr_keep,  // 1 keeps the stored bit
  input wire logic [ADDR_W-1:0] rd_addr,  // read location
  output logic [DATA_W-1:0] rd_word       // word at rd_addr
);

  logic [DATA_W-1:0] cells [DEPTH];

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_w,
                                              input logic [DATA_W-1:0] new_w,
                                              input logic [DATA_W-1:0] keep);
    merge = (old_w & keep) | (new_w & ~keep);
  endfunction

  // masked write, no reset: contents survive presetn
  always_ff @(posedge pclk) begin
    if (wr_go) begin
      cells[wr_addr] <= merge(cells[wr_addr], wr_data, wr_keep); // see (R3) (R4)
    end
  end

  assign rd_word = cells[rd_addr]; // see (R5)

endmodule
`default_nettype wire

/* File: bench/ebm_core_props.sv */
// port assertions for the block memory core
`timescale 1ns/100ps
`default_nettype none
module ebm_core_props #(
  parameter int DATA_W = 16
) (
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic [7:0] paddr, // address
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic pready, // ready
  input wire logic [31:0] prdata, // read data
  input wire logic pslverr, // error
  input wire logic rd_clk, // read clock
  input wire logic rd_clock_gate, // read gate
  input wire logic fetch_strobe, // read enable
  input wire logic [DATA_W-1:0] rd_data // port data
);
  logic prev_q;
  logic fire;
  logic bad;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= rd_clk;
    end
  end
  // any enabled read clock edge
  assign fire = (rd_clk != prev_q) && fetch_strobe && rd_clock_gate;
  assign bad = (paddr[1:0] != 2'b00) || (paddr > 8'h10);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////
  wait_state_a: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("ready not after one wait state");
  one_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  ready_qual_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  err_gate_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  bad_addr_a: assert property (pready && bad |-> pslverr)
    else $error("unmapped access not refused");
  good_addr_a: assert property (pready && !bad |-> !pslverr)
    else $error("mapped access refused");
  rd_hold_a: assert property (!$stable(rd_data) |-> $past(fire, 2))
    else $error("read data moved without enabled read");
  reset_zero_a: assert property ($rose(presetn) |-> rd_data == '0 && prdata == '0)
    else $error("outputs not cleared by reset");
  cover property (fire);
  cover property (pready && pslverr);
  cover property (pready && !bad);
endmodule
`default_nettype wire

/* File: bench/ebm_fabric_model.sv */
// fabric-side driver of both memory ports
`timescale 1ns/100ps
`default_nettype none
module ebm_fabric_model (
  input wire logic pclk, // clock
  output logic wr_clk, // write clock
  output logic wr_clock_gate, // write gate
  output logic wr_enable, // write enable
  output logic [7:0] wr_location, // write address
  output logic [15:0] wr_data, // write data
  output logic [15:0] wr_mask, // keep mask
  output logic rd_clk, // read clock
  output logic rd_clock_gate, // read gate
  output logic fetch_strobe, // read enable
  output logic [7:0] rd_location, // read address
  input wire logic [15:0] rd_data // read data
);
  initial begin
    {wr_clk, wr_clock_gate, wr_enable, wr_location, wr_data, wr_mask} = '0;
    {rd_clk, rd_clock_gate, fetch_strobe, rd_location} = '0;
  end
  // idle level, active edge, release with controls off and stale values inverted
  task automatic wr(input logic fall, input logic [7:0] a, input logic [15:0] v, input logic [15:0] m,
                    input logic we, input logic ce);
    @(posedge pclk);
    wr_clk <= fall;
    @(posedge pclk);
    {wr_clk, wr_enable, wr_clock_gate, wr_location, wr_data, wr_mask} <= {~fall, we, ce, a, v, m};
    @(posedge pclk);
    {wr_clk, wr_enable, wr_clock_gate} <= {fall, 2'b00};
    {wr_location, wr_data, wr_mask} <= ~{a, v, m};
    @(posedge pclk);
  endtask
  task automatic rd(input logic fall, input logic [7:0] a, input logic en, input logic ce,
                    output logic [15:0] q);
    @(posedge pclk);
    rd_clk <= fall;
    @(posedge pclk);
    {rd_clk, fetch_strobe, rd_clock_gate, rd_location} <= {~fall, en, ce, a};
    @(posedge pclk);
    {rd_clk, fetch_strobe, rd_clock_gate, rd_location} <= {fall, 2'b00, ~a};
    repeat (2) @(posedge pclk);
    q = rd_data;
  endtask
endmodule
`default_nettype wire

/* File: bench/test_embedded_block_ram_256x16.sv */
// self-checking bench for the block memory core
`timescale 1ns/100ps
`default_nettype none
module test_embedded_block_ram_256x16;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr, wr_location, rd_location;
  logic [31:0] pwdata, prdata, r;
  logic wr_clk, wr_clock_gate, wr_enable, rd_clk, rd_clock_gate, fetch_strobe;
  logic [15:0] wr_data, wr_mask, rd_data, d;
  int failures, total_checks;
  ebm_core u_ebm_core (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .prdata,
    .pslverr, .wr_clk, .wr_clock_gate, .wr_enable, .wr_location, .wr_data, .wr_mask, .rd_clk,
    .rd_clock_gate, .fetch_strobe, .rd_location, .rd_data);
  ebm_fabric_model u_ebm_fabric_model (.pclk, .wr_clk, .wr_clock_gate, .wr_enable, .wr_location,
    .wr_data, .wr_mask, .rd_clk, .rd_clock_gate, .fetch_strobe, .rd_location, .rd_data);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    if (failures == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  //////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    repeat (3000) @(posedge pclk);
    failures++;
    finish_test();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    failures = 0;
    total_checks = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ebm_pkg::CTRL_OFS, 32'h0);
    check(r, 32'h0);
    apb(1'b1, 8'h14, 32'hF);
    check({31'h0, e}, 32'h1);
    apb(1'b0, 8'h02, 32'h0);
    check({31'h0, e}, 32'h1);
    check(r, 32'h0);
    u_ebm_fabric_model.wr(1'b0, 8'h05, 16'hFFFF, 16'h0000, 1'b1, 1'b1);
    u_ebm_fabric_model.wr(1'b0, 8'h05, 16'h1234, 16'hFF00, 1'b1, 1'b1);
    u_ebm_fabric_model.rd(1'b0, 8'h05, 1'b1, 1'b1, d);
    check({16'h0, d}, 32'hFF34);
    apb(1'b0, ebm_pkg::WCOUNT_OFS, 32'h0);
    check(r, 32'h2);
    u_ebm_fabric_model.wr(1'b0, 8'h05, 16'h0000, 16'h0000, 1'b0, 1'b1);
    u_ebm_fabric_model.wr(1'b0, 8'h05, 16'h0000, 16'h0000, 1'b1, 1'b0);
    u_ebm_fabric_model.rd(1'b0, 8'h05, 1'b1, 1'b1, d);
    check({16'h0, d}, 32'hFF34);
    u_ebm_fabric_model.wr(1'b0, 8'h00, 16'hA5A5, 16'h0000, 1'b1, 1'b1);
    u_ebm_fabric_model.wr(1'b0, 8'hFF, 16'h5A5A, 16'h0000, 1'b1, 1'b1);
    u_ebm_fabric_model.rd(1'b0, 8'h00, 1'b1, 1'b1, d);
    check({16'h0, d}, 32'hA5A5);
    u_ebm_fabric_model.rd(1'b0, 8'hFF, 1'b1, 1'b1, d);
    check({16'h0, d}, 32'h5A5A);
    u_ebm_fabric_model.rd(1'b0, 8'h05, 1'b0, 1'b1, d);
    check({16'h0, d}, 32'h5A5A);
    u_ebm_fabric_model.rd(1'b0, 8'h05, 1'b1, 1'b0, d);
    check({16'h0, d}, 32'h5A5A);
    apb(1'b1, ebm_pkg::CTRL_OFS, 32'h3);
    u_ebm_fabric_model.wr(1'b1, 8'h80, 16'hC3C3, 16'h0000, 1'b1, 1'b1);
    u_ebm_fabric_model.rd(1'b1, 8'h80, 1'b1, 1'b1, d);
    check({16'h0, d}, 32'hC3C3);
    apb(1'b1, ebm_pkg::CTRL_OFS, 32'h4);
    apb(1'b1, ebm_pkg::PRE_ADDR_OFS, 32'h7);
    apb(1'b1, ebm_pkg::PRE_DATA_OFS, 32'hBEEF);
    apb(1'b1, ebm_pkg::PRE_ADDR_OFS, 32'h0);
    apb(1'b1, ebm_pkg::PRE_DATA_OFS, 32'h1111);
    apb(1'b0, ebm_pkg::STATUS_OFS, 32'h0);
    check({30'h0, r[1:0]}, 32'h3);
    u_ebm_fabric_model.wr(1'b0, 8'h07, 16'h0F0F, 16'h0000, 1'b1, 1'b1);
    apb(1'b1, ebm_pkg::CTRL_OFS, 32'h8);
    u_ebm_fabric_model.wr(1'b0, 8'h07, 16'h0F0F, 16'h0000, 1'b1, 1'b1);
    u_ebm_fabric_model.rd(1'b0, 8'h07, 1'b1, 1'b1, d);
    check({16'h0, d}, 32'hBEEF);
    u_ebm_fabric_model.rd(1'b0, 8'h00, 1'b1, 1'b1, d);
    check({16'h0, d}, 32'hA5A5);
    apb(1'b1, ebm_pkg::STATUS_OFS, 32'hFFFFFFFF);
    apb(1'b0, ebm_pkg::STATUS_OFS, 32'h0);
    check(r, 32'hA5A50006);
    apb(1'b0, ebm_pkg::WCOUNT_OFS, 32'h0);
    check(r, 32'h5);
    apb(1'b1, ebm_pkg::WCOUNT_OFS, 32'h0);
    apb(1'b0, ebm_pkg::WCOUNT_OFS, 32'h0);
    check(r, 32'h0);
    // mid-run reset: settings cleared, contents kept
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ebm_pkg::CTRL_OFS, 32'h0);
    check(r, 32'h0);
    u_ebm_fabric_model.rd(1'b0, 8'h07, 1'b1, 1'b1, d);
    check({16'h0, d}, 32'hBEEF);
    finish_test();
  end
endmodule
bind ebm_core ebm_core_props #(.DATA_W(DATA_W)) u_ebm_core_props (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .rd_clk(rd_clk), .rd_clock_gate(rd_clock_gate), .fetch_strobe(fetch_strobe), .rd_data(rd_data));
`default_nettype wire
